// File: shared/otpc_defines.vh
`ifndef OTPC_DEFINES_VH
`define OTPC_DEFINES_VH
`define OTPC_ADDR_W 19
`define OTPC_DATA_W 8
`define OTPC_CLK_MHZ 200
`define OTPC_PULSE_US 100
`define OTPC_PULSE_CYC (`OTPC_PULSE_US * `OTPC_CLK_MHZ)
`define OTPC_SETUP_US 2
`define OTPC_SETUP_CYC (`OTPC_SETUP_US * `OTPC_CLK_MHZ)
`define OTPC_READ_NS 150
`define OTPC_READ_CYC ((`OTPC_READ_NS * `OTPC_CLK_MHZ + 999) / 1000)
`define OTPC_MAX_PULSES 25
`define OTPC_ID_BIT 9
`define OTPC_SEL_BIT 0
`define OTPC_ERASED 8'hff
`define OTPC_OP_READ 2'h0
`define OTPC_OP_PROG 2'h1
`define OTPC_OP_IDENT 2'h2
`define OTPC_OP_FINAL 2'h3
`endif

// File: rtl/otpc_timer.v
`timescale 1ns/1ps
module otpc_timer #(
  parameter W = 16
) (
  input wire clk_i,
  input wire srst_i,
  input wire ce_i,
  input wire load_i,
  input wire [W-1:0] count_i,
  output wire done_o
);
  reg [W-1:0] cnt;
  assign done_o = (cnt == {W{1'b0}});
  always @(posedge clk_i) begin
    if (srst_i) begin
      cnt <= {W{1'b0}};
    end else if (ce_i) begin
      if (load_i) begin
        cnt <= count_i;
      end else if (!done_o) begin
        cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// File: rtl/otpc_ctrl.v
// Behaviour
// - Programming holds output gate high, sets address and data, then one 100us select-low pulse unless the byte is ff.
// - After each pulse the byte is read back, retrying up to 25 pulses in all.
// - Addresses are programmed in turn up to LAST_I, stopping at the first failing one; the final read-back pass at normal supply is a separate op (OTPC_OP_FINAL).
// - Devices sharing lines are kept idle by their own select held high.
// - Verify reads with both enables low and program supply still on.
// - Identify forces high voltage on the trigger line, byte select picks maker or part byte.
// - During identify all other address lines are held low.
// - Select is decoded per device and output gate follows the read strobe.
`timescale 1ns/1ps
`include "otpc_defines.vh"
module otpc_ctrl #(
  parameter PULSE_CYC = `OTPC_PULSE_CYC,
  parameter SETUP_CYC = `OTPC_SETUP_CYC,
  parameter READ_CYC = `OTPC_READ_CYC,
  parameter MAX_PULSES = `OTPC_MAX_PULSES
) (
  input wire CLK_I,
  input wire SRST_I,
  input wire CE_I,
  input wire START_I,
  input wire [1:0] OP_I,
  input wire [`OTPC_ADDR_W-1:0] ADDR_I,
  input wire [`OTPC_ADDR_W-1:0] LAST_I,
  input wire [`OTPC_DATA_W-1:0] WDATA_I,
  input wire ID_BYTE_I,
  output wire BUSY_O,
  output wire WREQ_O,
  output reg DONE_O,
  output reg FAIL_O,
  output reg PARITY_OK_O,
  output reg [`OTPC_ADDR_W-1:0] FAIL_ADDR_O,
  output reg [`OTPC_DATA_W-1:0] RDATA_O,
  output reg [`OTPC_ADDR_W-1:0] WORD_ADDRESS_O,
  output reg IDENTIFY_HIGH_VOLTAGE_O,
  output reg PROG_SUPPLY_O,
  output reg DEV_SELECT_N_O,
  output reg OUT_GATE_N_O,
  output reg [`OTPC_DATA_W-1:0] DATA_PORT_O,
  output reg DATA_PORT_OE_N_O,
  input wire [`OTPC_DATA_W-1:0] DATA_PORT_I
);
  localparam S_IDLE = 3'd0;
  localparam S_SETUP = 3'd1;
  localparam S_PULSE = 3'd2;
  localparam S_HOLD = 3'd3;
  localparam S_READ = 3'd4;
  localparam S_CHECK = 3'd5;
  localparam S_NEXT = 3'd6;
  localparam TW = 16;
  // Timer load and done detect add two cycles to the select-low time
  localparam PULSE_LOAD = PULSE_CYC - 2;

  reg [2:0] state;
  reg [1:0] op;
  reg [4:0] pulses;
  reg [`OTPC_ADDR_W-1:0] last;
  reg [`OTPC_DATA_W-1:0] wdata;
  reg [`OTPC_DATA_W-1:0] sync0;
  reg [`OTPC_DATA_W-1:0] sync1;
  reg tload;
  reg [TW-1:0] tcount;
  wire tdone;

  function odd_parity;
    input [`OTPC_DATA_W-1:0] b;
    begin
      odd_parity = ^b;
    end
  endfunction

  otpc_timer #(.W(TW)) u_timer (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .ce_i(CE_I),
    .load_i(tload),
    .count_i(tcount),
    .done_o(tdone)
  );

  assign BUSY_O = (state != S_IDLE);
  assign WREQ_O = (state == S_NEXT) && (op == `OTPC_OP_PROG) && !tload;

  always @(posedge CLK_I) begin
    if (SRST_I) begin
      sync0 <= {`OTPC_DATA_W{1'b0}};
      sync1 <= {`OTPC_DATA_W{1'b0}};
    end else if (CE_I) begin
      sync0 <= DATA_PORT_I;
      sync1 <= sync0;
    end
  end

  always @(posedge CLK_I) begin
    if (SRST_I) begin
      state <= S_IDLE;
      op <= `OTPC_OP_READ;
      pulses <= 5'h00;
      last <= {`OTPC_ADDR_W{1'b0}};
      wdata <= `OTPC_ERASED;
      tload <= 1'b0;
      tcount <= {TW{1'b0}};
      DONE_O <= 1'b0;
      FAIL_O <= 1'b0;
      PARITY_OK_O <= 1'b0;
      FAIL_ADDR_O <= {`OTPC_ADDR_W{1'b0}};
      RDATA_O <= `OTPC_ERASED;
      WORD_ADDRESS_O <= {`OTPC_ADDR_W{1'b0}};
      IDENTIFY_HIGH_VOLTAGE_O <= 1'b0;
      PROG_SUPPLY_O <= 1'b0;
      DEV_SELECT_N_O <= 1'b1;
      OUT_GATE_N_O <= 1'b1;
      DATA_PORT_O <= `OTPC_ERASED;
      DATA_PORT_OE_N_O <= 1'b1;
    end else if (CE_I) begin
      tload <= 1'b0;
      DONE_O <= 1'b0;
      case (state)
        S_IDLE: begin
          if (START_I) begin
            op <= OP_I;
            last <= LAST_I;
            wdata <= WDATA_I;
            pulses <= 5'h00;
            FAIL_O <= 1'b0;
            tload <= 1'b1;
            if (OP_I == `OTPC_OP_IDENT) begin
              WORD_ADDRESS_O <= {`OTPC_ADDR_W{1'b0}};
              WORD_ADDRESS_O[`OTPC_SEL_BIT] <= ID_BYTE_I;
              IDENTIFY_HIGH_VOLTAGE_O <= 1'b1;
            end else begin
              WORD_ADDRESS_O <= ADDR_I;
            end
            if (OP_I == `OTPC_OP_PROG) begin
              PROG_SUPPLY_O <= 1'b1;
              OUT_GATE_N_O <= 1'b1;
              DATA_PORT_O <= WDATA_I;
              DATA_PORT_OE_N_O <= 1'b0;
              tcount <= SETUP_CYC[TW-1:0];
              state <= S_SETUP;
            end else begin
              PROG_SUPPLY_O <= 1'b0;
              tcount <= SETUP_CYC[TW-1:0];
              state <= S_HOLD;
            end
          end
        end
        S_SETUP: begin
          if (tdone && !tload) begin
            if (wdata == `OTPC_ERASED) begin
              DATA_PORT_OE_N_O <= 1'b1;
              tload <= 1'b1;
              tcount <= SETUP_CYC[TW-1:0];
              state <= S_HOLD;
            end else begin
              DEV_SELECT_N_O <= 1'b0;
              pulses <= pulses + 5'h01;
              tload <= 1'b1;
              tcount <= PULSE_LOAD[TW-1:0];
              state <= S_PULSE;
            end
          end
        end
        S_PULSE: begin
          if (tdone && !tload) begin
            DEV_SELECT_N_O <= 1'b1;
            tload <= 1'b1;
            tcount <= SETUP_CYC[TW-1:0];
            state <= S_HOLD;
          end
        end
        S_HOLD: begin
          if (tdone && !tload) begin
            DATA_PORT_OE_N_O <= 1'b1;
            DEV_SELECT_N_O <= 1'b0;
            OUT_GATE_N_O <= 1'b0;
            tload <= 1'b1;
            tcount <= READ_CYC[TW-1:0] + 16'd2;
            state <= S_READ;
          end
        end
        S_READ: begin
          if (tdone && !tload) begin
            RDATA_O <= sync1;
            DEV_SELECT_N_O <= 1'b1;
            OUT_GATE_N_O <= 1'b1;
            state <= S_CHECK;
          end
        end
        S_CHECK: begin
          state <= S_NEXT;
          if (op == `OTPC_OP_IDENT) begin
            PARITY_OK_O <= odd_parity(RDATA_O);
            IDENTIFY_HIGH_VOLTAGE_O <= 1'b0;
          end else if ((op == `OTPC_OP_PROG && RDATA_O != wdata) ||
                       (op == `OTPC_OP_FINAL && RDATA_O != WDATA_I)) begin
            if (op == `OTPC_OP_PROG && pulses < MAX_PULSES[4:0]) begin
              DATA_PORT_O <= wdata;
              DATA_PORT_OE_N_O <= 1'b0;
              tload <= 1'b1;
              tcount <= SETUP_CYC[TW-1:0];
              state <= S_SETUP;
            end else begin
              FAIL_O <= 1'b1;
              FAIL_ADDR_O <= WORD_ADDRESS_O;
            end
          end
        end
        S_NEXT: begin
          if (op == `OTPC_OP_READ || op == `OTPC_OP_IDENT || FAIL_O ||
              WORD_ADDRESS_O == last) begin
            DONE_O <= 1'b1;
            PROG_SUPPLY_O <= 1'b0;
            DATA_PORT_OE_N_O <= 1'b1;
            state <= S_IDLE;
          end else if (op == `OTPC_OP_FINAL || !tload) begin
            WORD_ADDRESS_O <= WORD_ADDRESS_O + 19'h00001;
            wdata <= WDATA_I;
            pulses <= 5'h00;
            tload <= 1'b1;
            tcount <= SETUP_CYC[TW-1:0];
            if (op == `OTPC_OP_PROG) begin
              DATA_PORT_O <= WDATA_I;
              DATA_PORT_OE_N_O <= 1'b0;
              state <= S_SETUP;
            end else begin
              state <= S_HOLD;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

// File: test/otpc_ctrl_sva.sv
`timescale 1ns/1ps
module otpc_ctrl_sva #(
  parameter PULSE_CYC = 20,
  parameter MAX_PULSES = 25
) (
  input wire CLK_I,
  input wire SRST_I,
  input wire ID_BYTE_I,
  input wire [18:0] WORD_ADDRESS_O,
  input wire IDENTIFY_HIGH_VOLTAGE_O,
  input wire PROG_SUPPLY_O,
  input wire DEV_SELECT_N_O,
  input wire OUT_GATE_N_O,
  input wire [7:0] DATA_PORT_O,
  input wire DATA_PORT_OE_N_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  wire pgm = PROG_SUPPLY_O && OUT_GATE_N_O && !DEV_SELECT_N_O;
  wire hv = IDENTIFY_HIGH_VOLTAGE_O;
  reg [15:0] low_cnt;
  reg [5:0] npulse;
  always @(posedge CLK_I) begin
    low_cnt <= DEV_SELECT_N_O ? 16'h0 : low_cnt + 16'h1;
    if (SRST_I || $changed(WORD_ADDRESS_O))
      npulse <= 6'h0;
    else if (pgm && $fell(DEV_SELECT_N_O))
      npulse <= npulse + 6'h1;
  end
  sequence s_pgm2; pgm ##1 pgm; endsequence
  sequence s_pend; $rose(DEV_SELECT_N_O) && $past(pgm); endsequence
  property p_len; s_pend |-> low_cnt == PULSE_CYC; endproperty
  a_len: assert property (p_len) else $error("pulse width");
  property p_drv; pgm |-> !DATA_PORT_OE_N_O; endproperty
  a_drv: assert property (p_drv) else $error("data not driven");
  property p_stb;
    s_pgm2 |-> $stable(DATA_PORT_O) && $stable(WORD_ADDRESS_O);
  endproperty
  a_stb: assert property (p_stb) else $error("pulse unstable");
  property p_clash; !OUT_GATE_N_O |-> DATA_PORT_OE_N_O; endproperty
  a_clash: assert property (p_clash) else $error("contention");
  property p_vfy;
    PROG_SUPPLY_O && !OUT_GATE_N_O |-> !DEV_SELECT_N_O;
  endproperty
  a_vfy: assert property (p_vfy) else $error("verify enables");
  property p_idl;
    hv |-> (WORD_ADDRESS_O & 19'h7fdfe) == 19'h0 && !PROG_SUPPLY_O;
  endproperty
  a_idl: assert property (p_idl) else $error("id lines");
  property p_ids;
    hv && !OUT_GATE_N_O |-> WORD_ADDRESS_O[0] == ID_BYTE_I && !DEV_SELECT_N_O;
  endproperty
  a_ids: assert property (p_ids) else $error("id select");
  property p_cnt; npulse <= MAX_PULSES; endproperty
  a_cnt: assert property (p_cnt) else $error("too many pulses");
endmodule
bind otpc_ctrl otpc_ctrl_sva #(.PULSE_CYC(PULSE_CYC), .MAX_PULSES(MAX_PULSES))
  u_sva (.CLK_I(CLK_I), .SRST_I(SRST_I), .ID_BYTE_I(ID_BYTE_I),
  .WORD_ADDRESS_O(WORD_ADDRESS_O), .PROG_SUPPLY_O(PROG_SUPPLY_O),
  .IDENTIFY_HIGH_VOLTAGE_O(IDENTIFY_HIGH_VOLTAGE_O),
  .DEV_SELECT_N_O(DEV_SELECT_N_O), .OUT_GATE_N_O(OUT_GATE_N_O),
  .DATA_PORT_O(DATA_PORT_O), .DATA_PORT_OE_N_O(DATA_PORT_OE_N_O));

// File: test/otpc_eprom_model.sv
`timescale 1ns/1ps
module otpc_eprom_model #(
  parameter [7:0] MAKER = 8'h8a, // Arbitrary code
  parameter [7:0] PART = 8'h15 // Arbitrary code
) (
  input wire [18:0] addr_i,
  input wire sel_n_i,
  input wire gate_n_i,
  input wire supply_i,
  input wire hv_i,
  input wire bad_id_i,
  input wire [7:0] din_i,
  output wire [7:0] q_o,
  output wire drv_o
);
  reg [7:0] mem [0:524287];
  integer i;
  initial for (i = 0; i < 524288; i = i + 1) mem[i] = 8'hff;
  // Gate level just before the select edge, free of same-step races
  wire #1 gate_held = gate_n_i;
  // Store at pulse end; a held-high select never stores
  always @(posedge sel_n_i)
    if (supply_i && gate_held)
      mem[addr_i] <= mem[addr_i] & din_i;
  assign drv_o = !sel_n_i && !gate_n_i;
  assign q_o = hv_i ? (addr_i[0] ? PART : MAKER) ^ {bad_id_i, 7'h0}
    : mem[addr_i];
endmodule

// File: test/otpc_ctrl_tb_top.sv
`timescale 1ns/1ps
module otpc_ctrl_tb_top;
  localparam [7:0] MAKER = 8'h8a; // Arbitrary code, odd parity
  localparam [7:0] PART = 8'h15; // Arbitrary code, odd parity
  reg clk = 1'b0, rst = 1'b1, start = 1'b0, id_byte = 1'b0, bad_id = 1'b0;
  reg [1:0] op = 2'h0;
  reg [18:0] addr = 19'h0, last = 19'h0;
  reg [7:0] tab [0:15];
  reg [7:0] last_bus = 8'h0;
  integer bad_count = 0, num_checks = 0, pulses = 0, k;
  wire busy, wreq, done, fail, par_ok, hv, sup, sel_n, gate_n, oe_n, drv;
  wire [18:0] wa, fail_addr;
  wire [7:0] rdata, dout, q, bus;
  wire [3:0] idx = wreq ? wa[3:0] + 4'h1 : (busy ? wa[3:0] : addr[3:0]);
  assign bus = drv ? q : (!oe_n ? dout : ~last_bus);
  always #2.5 clk = ~clk;
  always @(posedge clk) last_bus <= bus;
  reg sel_q = 1'b1, ce = 1'b1;
  // Count select falls with gate high, sampled on the clock
  always @(posedge clk) begin
    sel_q <= sel_n;
    if (sel_q && !sel_n && gate_n && sup) pulses = pulses + 1;
  end
  otpc_ctrl #(.PULSE_CYC(20), .SETUP_CYC(4), .READ_CYC(4), .MAX_PULSES(25))
    uut (.CLK_I(clk), .SRST_I(rst), .CE_I(ce), .START_I(start), .OP_I(op),
    .ADDR_I(addr), .LAST_I(last), .WDATA_I(tab[idx]), .ID_BYTE_I(id_byte),
    .BUSY_O(busy), .WREQ_O(wreq), .DONE_O(done), .FAIL_O(fail),
    .PARITY_OK_O(par_ok), .FAIL_ADDR_O(fail_addr), .RDATA_O(rdata),
    .WORD_ADDRESS_O(wa), .IDENTIFY_HIGH_VOLTAGE_O(hv), .PROG_SUPPLY_O(sup),
    .DEV_SELECT_N_O(sel_n), .OUT_GATE_N_O(gate_n), .DATA_PORT_O(dout),
    .DATA_PORT_OE_N_O(oe_n), .DATA_PORT_I(bus));
  otpc_eprom_model #(.MAKER(MAKER), .PART(PART)) dev (.addr_i(wa),
    .sel_n_i(sel_n), .gate_n_i(gate_n), .supply_i(sup), .hv_i(hv),
    .bad_id_i(bad_id), .din_i(bus), .q_o(q), .drv_o(drv));
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input string name, input [18:0] exp, input [18:0] got);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED %s exp %h got %h", name, exp, got);
      end
    end
  endtask
  task run(input [1:0] o, input [18:0] a, input [18:0] l);
    integer n;
    begin
      @(posedge clk);
      #1 op = o;
      addr = a;
      last = l;
      start = 1'b1;
      pulses = 0;
      @(posedge clk);
      #1 start = 1'b0;
      for (n = 0; n < 5000 && done !== 1'b1; n = n + 1) begin
        @(posedge clk);
        #1;
      end
      if (n == 5000) begin
        chk("done", 1, 0);
        wrap_up;
      end
    end
  endtask
  task t_prog;
    begin
      tab[0] = 8'ha5;
      tab[1] = 8'hff;
      tab[2] = 8'h3c;
      tab[3] = 8'h00;
      run(2'h1, 19'h0, 19'h3);
      chk("fail", 0, fail);
      chk("pulses", 3, pulses);
      for (k = 0; k < 5; k = k + 1) begin
        run(2'h0, k * 2, k * 2);
        chk("rdata", k < 2 ? tab[k * 2] : 8'hff, rdata);
      end
    end
  endtask
  task t_over;
    begin
      tab[0] = 8'hf0;
      run(2'h1, 19'h0, 19'h0);
      chk("fail", 1, fail);
      chk("pulses", 25, pulses);
      run(2'h0, 19'h0, 19'h0);
      chk("merge", 8'ha0, rdata);
      tab[0] = 8'ha0;
      run(2'h3, 19'h0, 19'h3);
      chk("final", 0, fail);
      tab[2] = 8'h3d;
      run(2'h3, 19'h0, 19'h3);
      chk("final", 1, fail);
      chk("fail addr", 2, fail_addr);
    end
  endtask
  task t_ce;
    integer n;
    begin
      @(posedge clk);
      #1 op = 2'h0;
      addr = 19'h2;
      last = 19'h2;
      start = 1'b1;
      @(posedge clk);
      #1 start = 1'b0;
      ce = 1'b0;
      repeat (20) @(posedge clk);
      #1 chk("frozen busy", 1, busy);
      chk("frozen select", 1, sel_n);
      ce = 1'b1;
      for (n = 0; n < 100 && done !== 1'b1; n = n + 1) begin
        @(posedge clk);
        #1;
      end
      chk("ce done", 1, done);
      chk("ce rdata", 8'h3c, rdata);
    end
  endtask
  task t_id;
    begin
      for (k = 0; k < 3; k = k + 1) begin
        id_byte = k[0];
        bad_id = k[1];
        run(2'h2, 19'h0, 19'h0);
        chk("parity", !k[1], par_ok);
        chk("code", (k[0] ? PART : MAKER) ^ {k[1], 7'h0}, rdata);
      end
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    t_prog;
    t_over;
    t_ce;
    t_id;
    wrap_up;
  end
endmodule
